/* File: design/mcx_core_regs.vh */
// constants for the mcx instruction execution core
`ifndef MCX_CORE_REGS_VH
`define MCX_CORE_REGS_VH

// reset and vector addresses in program space
`define MCX_RST_PC 12'h000
`define MCX_IRQ_VEC 12'hFF0

// short-direct working registers, first two are the pointers
`define MCX_REG_BASE 8'h80

// cycles per instruction group
`define MCX_CYC_ALU 3'h4
`define MCX_CYC_REL 3'h2
`define MCX_CYC_BTB 3'h5
`define MCX_CYC_BIT 3'h4
`define MCX_CYC_CTL 3'h2
`define MCX_CYC_JMP 3'h4

// opcode group fields
`define MCX_GRP_BIT 3'h4
`define MCX_GRP_ALU 3'h5
`define MCX_GRP_SHORT 4'hC
`define MCX_GRP_MISC 4'hD
`define MCX_GRP_JUMP 4'hE
`define MCX_GRP_CALL 4'hF

// arithmetic/logic function codes, opcode bits 4..2
`define MCX_FN_ADD 3'h0
`define MCX_FN_AND 3'h1
`define MCX_FN_CMP 3'h2
`define MCX_FN_SUB 3'h3
`define MCX_FN_INC 3'h4
`define MCX_FN_DEC 3'h5
`define MCX_FN_CLR 3'h6

// addressing modes, opcode bits 1..0
`define MCX_MODE_DIR 2'h2
`define MCX_MODE_IMM 2'h3

// inherent opcodes, low nibble of the misc group
`define MCX_MS_NOP 4'h0
`define MCX_MS_RET 4'h1
`define MCX_MS_INTERRUPT_RETURN_OP 4'h2
`define MCX_MS_STOP 4'h3
`define MCX_MS_WAIT 4'h4
`define MCX_MS_COM 4'h5
`define MCX_MS_RLC 4'h6
`define MCX_MS_SLA 4'h7
`define MCX_MS_CLRA 4'h8
`define MCX_MS_INCA 4'h9
`define MCX_MS_DECA 4'hA

// return stack
`define MCX_STK_DEPTH 3'h6

`endif

/* File: design/mcx_stack_mem.v */
// return address stack memory with registered read
`timescale 1ns/1ps
module mcx_stack_mem (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// write side
	input wire wrEn,
	input wire [2:0] wrAddr,
	input wire [11:0] wrData,
	// read side
	input wire [2:0] rdAddr,
	output reg [11:0] rdData
);

	reg [11:0] mem [0:5];

	// cells hold no reset, only the read register does
	always @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// read data one cycle after the address
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdData <= 12'h000;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

/* File: design/mcx_core_exec.v */
// instruction decode and execution for the 8-bit core
`timescale 1ns/1ps
`include "mcx_core_regs.vh"
module mcx_core_exec (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// program memory, asynchronous read
	output reg [11:0] progAddr_r,
	input wire [7:0] progData,
	// data space, asynchronous read
	output reg [7:0] dataAddr_r,
	input wire [7:0] dataRdata,
	output reg [7:0] dataWdata_r,
	output reg dataWe_r,
	// pins from outside
	input wire irqReq,
	input wire wdogSel,
	// status
	output reg [7:0] acc_r,
	output reg zero_r,
	output reg carry_r,
	output reg stopMode_r,
	output reg waitMode_r,
	output wire instrStart
);

	reg [2:0] cyc_r, cyc_nxt;
	reg [7:0] opcode_r, opcode_nxt;
	reg [7:0] byte1_r, byte1_nxt;
	reg [7:0] byte2_r, byte2_nxt;
	reg [11:0] pcInst_r, pcInst_nxt;
	reg [11:0] progAddr_nxt;
	reg [7:0] dataAddr_nxt, dataWdata_nxt;
	reg dataWe_nxt;
	reg [7:0] acc_nxt;
	reg zero_nxt, carry_nxt, zeroSave_r, zeroSave_nxt, carrySave_r, carrySave_nxt;
	reg inIrq_r, inIrq_nxt, stopMode_nxt, waitMode_nxt;
	reg [2:0] sp_r, sp_nxt;
	reg push, pop;
	reg [11:0] pushData;
	reg [1:0] irqMeta_r, wdogMeta_r;
	wire [11:0] stackRd;
	wire [7:0] op;
	wire irqPend;
	reg [2:0] cycles;
	reg [8:0] sum;
	reg [7:0] opnd, mask;
	reg last, taken;

	// synchronisers: only bit 1 is read by logic
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irqMeta_r <= 2'h0;
			wdogMeta_r <= 2'h0;
		end else begin
			irqMeta_r <= {irqMeta_r[0], irqReq};
			wdogMeta_r <= {wdogMeta_r[0], wdogSel};
		end
	end

	// no nesting: a pending request waits for the interrupt return
	assign irqPend = irqMeta_r[1] & ~inIrq_r;
	// opcode arrives on the bus in cycle 0, held afterwards
	assign op = (cyc_r == 3'h0) ? progData : opcode_r;
	assign instrStart = (cyc_r == 3'h0) & ~stopMode_r & ~waitMode_r & ~irqPend;

	// cycle count per group
	always @* begin
		cycles = `MCX_CYC_CTL;
		if (op[7:5] == `MCX_GRP_ALU || op[7:4] == `MCX_GRP_SHORT) begin
			cycles = `MCX_CYC_ALU;
		end else if (!op[7]) begin
			cycles = `MCX_CYC_REL;
		end else if (op[7:5] == `MCX_GRP_BIT) begin
			cycles = op[4] ? `MCX_CYC_BIT : `MCX_CYC_BTB;
		end else if (op[7:4] == `MCX_GRP_JUMP || op[7:4] == `MCX_GRP_CALL) begin
			cycles = `MCX_CYC_JMP;
		end else if (op[3:0] >= `MCX_MS_COM && op[3:0] <= `MCX_MS_DECA) begin
			cycles = `MCX_CYC_ALU;
		end
	end

	// sequencing and execution
	always @* begin
		cyc_nxt = cyc_r + 3'h1;
		opcode_nxt = opcode_r;
		byte1_nxt = byte1_r;
		byte2_nxt = byte2_r;
		pcInst_nxt = pcInst_r;
		progAddr_nxt = progAddr_r + 12'h001;
		dataAddr_nxt = dataAddr_r;
		dataWdata_nxt = dataWdata_r;
		dataWe_nxt = 1'b0;
		acc_nxt = acc_r;
		zero_nxt = zero_r;
		carry_nxt = carry_r;
		zeroSave_nxt = zeroSave_r;
		carrySave_nxt = carrySave_r;
		inIrq_nxt = inIrq_r;
		stopMode_nxt = stopMode_r;
		waitMode_nxt = waitMode_r;
		push = 1'b0;
		pop = 1'b0;
		pushData = progAddr_r;
		sum = 9'h000;
		opnd = (op[1:0] == `MCX_MODE_IMM) ? byte1_r : dataRdata;
		mask = 8'h01 << op[2:0];
		last = (cyc_r == cycles - 3'h1);
		taken = 1'b0;
		if ((stopMode_r || waitMode_r || cyc_r == 3'h0) && irqPend) begin
			// interrupt entry replaces the fetch, flags saved for the return
			push = 1'b1;
			zeroSave_nxt = zero_r;
			carrySave_nxt = carry_r;
			inIrq_nxt = 1'b1;
			stopMode_nxt = 1'b0;
			waitMode_nxt = 1'b0;
			progAddr_nxt = `MCX_IRQ_VEC;
			cyc_nxt = 3'h0;
		end else if (stopMode_r || waitMode_r) begin
			// asleep: hold the next fetch address
			progAddr_nxt = progAddr_r;
			cyc_nxt = 3'h0;
		end else begin
			case (cyc_r)
				3'h0: begin
					opcode_nxt = progData;
					pcInst_nxt = progAddr_r;
					dataAddr_nxt = `MCX_REG_BASE | {6'h00, op[1:0]};
				end
				3'h1: begin
					byte1_nxt = progData;
					if (op[7:5] == `MCX_GRP_ALU && !op[1]) begin
						dataAddr_nxt = dataRdata;
					end else if (op[7:5] == `MCX_GRP_BIT || op[7:5] == `MCX_GRP_ALU) begin
						dataAddr_nxt = progData;
					end
				end
				3'h2: begin
					byte2_nxt = progData;
					if (op[7:5] == `MCX_GRP_ALU) begin
						case (op[4:2])
							`MCX_FN_ADD: begin
								sum = {1'b0, acc_r} + {1'b0, opnd};
								acc_nxt = sum[7:0];
								carry_nxt = sum[8];
								zero_nxt = (sum[7:0] == 8'h00);
							end
							`MCX_FN_AND: begin
								acc_nxt = acc_r & opnd;
								carry_nxt = 1'b0;
								zero_nxt = ((acc_r & opnd) == 8'h00);
							end
							`MCX_FN_CMP, `MCX_FN_SUB: begin
								sum = {1'b0, acc_r} - {1'b0, opnd};
								if (op[4:2] == `MCX_FN_SUB) begin
									acc_nxt = sum[7:0];
								end
								carry_nxt = sum[8];
								zero_nxt = (sum[7:0] == 8'h00);
							end
							`MCX_FN_INC, `MCX_FN_DEC: begin
								if (op[1:0] != `MCX_MODE_IMM) begin
									dataWdata_nxt = op[2] ? opnd - 8'h01 : opnd + 8'h01;
									dataWe_nxt = 1'b1;
									zero_nxt = (dataWdata_nxt == 8'h00);
								end
							end
							`MCX_FN_CLR: begin
								if (op[1:0] != `MCX_MODE_IMM) begin
									dataWdata_nxt = 8'h00;
									dataWe_nxt = 1'b1;
								end
							end
							default: begin
								dataWe_nxt = 1'b0;
							end
						endcase
					end else if (op[7:4] == `MCX_GRP_SHORT) begin
						dataWdata_nxt = op[3] ? dataRdata - 8'h01 : dataRdata + 8'h01;
						dataWe_nxt = 1'b1;
						zero_nxt = (dataWdata_nxt == 8'h00);
					end else if (op[7:5] == `MCX_GRP_BIT) begin
						if (!op[4]) begin
							carry_nxt = dataRdata[op[2:0]];
						end else begin
							dataWdata_nxt = op[3] ? (dataRdata | mask) : (dataRdata & ~mask);
							dataWe_nxt = 1'b1;
						end
					end else if (op[7:4] == `MCX_GRP_MISC) begin
						case (op[3:0])
							`MCX_MS_COM: begin
								acc_nxt = ~acc_r;
								carry_nxt = acc_r[7];
							end
							`MCX_MS_RLC: begin
								acc_nxt = {acc_r[6:0], carry_r};
								carry_nxt = acc_r[7];
							end
							`MCX_MS_SLA: begin
								acc_nxt = {acc_r[6:0], 1'b0};
								carry_nxt = acc_r[7];
							end
							`MCX_MS_CLRA: begin
								acc_nxt = 8'h00;
								carry_nxt = 1'b0;
							end
							`MCX_MS_INCA: begin
								acc_nxt = acc_r + 8'h01;
							end
							`MCX_MS_DECA: begin
								acc_nxt = acc_r - 8'h01;
							end
							default: begin
								acc_nxt = acc_r;
							end
						endcase
						if (op[3:0] >= `MCX_MS_COM && op[3:0] <= `MCX_MS_DECA) begin
							zero_nxt = (acc_nxt == 8'h00);
						end
					end
				end
				default: begin
					dataWe_nxt = 1'b0;
				end
			endcase
			if (last) begin
				cyc_nxt = 3'h0;
				progAddr_nxt = pcInst_r + 12'h001;
				if (!op[7]) begin
					case (op[6:5])
						2'h0: taken = ~zero_r;
						2'h1: taken = ~carry_r;
						2'h2: taken = zero_r;
						default: taken = carry_r;
					endcase
					if (taken) begin
						progAddr_nxt = pcInst_r + 12'h001 + {{7{op[4]}}, op[4:0]};
					end
				end else if (op[7:5] == `MCX_GRP_BIT) begin
					progAddr_nxt = pcInst_r + (op[4] ? 12'h002 : 12'h003);
					if (!op[4] && carry_r == op[3]) begin
						progAddr_nxt = pcInst_r + 12'h002 + {{4{byte2_r[7]}}, byte2_r};
					end
				end else if (op[7:5] == `MCX_GRP_ALU) begin
					// clear direct carries a spare third byte
					if (op[4:2] == `MCX_FN_CLR && op[1:0] == `MCX_MODE_DIR) begin
						progAddr_nxt = pcInst_r + 12'h003;
					end else if (op[1]) begin
						progAddr_nxt = pcInst_r + 12'h002;
					end
				end else if (op[7:4] == `MCX_GRP_JUMP || op[7:4] == `MCX_GRP_CALL) begin
					progAddr_nxt = {op[3:0], byte1_r};
					push = (op[7:4] == `MCX_GRP_CALL);
					pushData = pcInst_r + 12'h002;
				end else if (op[7:4] == `MCX_GRP_MISC) begin
					case (op[3:0])
						`MCX_MS_RET: begin
							pop = 1'b1;
							progAddr_nxt = stackRd;
						end
						`MCX_MS_INTERRUPT_RETURN_OP: begin
							pop = 1'b1;
							progAddr_nxt = stackRd;
							zero_nxt = zeroSave_r;
							carry_nxt = carrySave_r;
							inIrq_nxt = 1'b0;
						end
						`MCX_MS_STOP: begin
							stopMode_nxt = ~wdogMeta_r[1];
							waitMode_nxt = wdogMeta_r[1];
						end
						`MCX_MS_WAIT: begin
							waitMode_nxt = 1'b1;
						end
						`MCX_MS_SLA, `MCX_MS_CLRA, `MCX_MS_INCA, `MCX_MS_DECA: begin
							progAddr_nxt = pcInst_r + 12'h002;
						end
						default: begin
							progAddr_nxt = pcInst_r + 12'h001;
						end
					endcase
				end
			end
		end
		// stack pointer saturates at full depth
		sp_nxt = sp_r;
		if (push && sp_r != `MCX_STK_DEPTH) begin
			sp_nxt = sp_r + 3'h1;
		end else if (pop && sp_r != 3'h0) begin
			sp_nxt = sp_r - 3'h1;
		end
	end

	// state registers
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cyc_r <= 3'h0;
			opcode_r <= 8'h00;
			byte1_r <= 8'h00;
			byte2_r <= 8'h00;
			pcInst_r <= `MCX_RST_PC;
			progAddr_r <= `MCX_RST_PC;
			dataAddr_r <= 8'h00;
			dataWdata_r <= 8'h00;
			dataWe_r <= 1'b0;
			acc_r <= 8'h00;
			zero_r <= 1'b0;
			carry_r <= 1'b0;
			zeroSave_r <= 1'b0;
			carrySave_r <= 1'b0;
			inIrq_r <= 1'b0;
			stopMode_r <= 1'b0;
			waitMode_r <= 1'b0;
			sp_r <= 3'h0;
		end else begin
			cyc_r <= cyc_nxt;
			opcode_r <= opcode_nxt;
			byte1_r <= byte1_nxt;
			byte2_r <= byte2_nxt;
			pcInst_r <= pcInst_nxt;
			progAddr_r <= progAddr_nxt;
			dataAddr_r <= dataAddr_nxt;
			dataWdata_r <= dataWdata_nxt;
			dataWe_r <= dataWe_nxt;
			acc_r <= acc_nxt;
			zero_r <= zero_nxt;
			carry_r <= carry_nxt;
			zeroSave_r <= zeroSave_nxt;
			carrySave_r <= carrySave_nxt;
			inIrq_r <= inIrq_nxt;
			stopMode_r <= stopMode_nxt;
			waitMode_r <= waitMode_nxt;
			sp_r <= sp_nxt;
		end
	end

	// return stack, a full push overwrites the top cell
	mcx_stack_mem stack (
		.sys_clk(sys_clk),
		.rst(rst),
		.wrEn(push),
		.wrAddr((sp_r == `MCX_STK_DEPTH) ? sp_r - 3'h1 : sp_r),
		.wrData(pushData),
		.rdAddr((sp_r == 3'h0) ? 3'h0 : sp_r - 3'h1),
		.rdData(stackRd)
	);

endmodule

/* File: test/mcx_core_exec_checker.sv */
// port assertions for the instruction execution core
`timescale 1ns/1ps
module mcx_core_exec_checker (
	// clock and reset
	input wire sys_clk,
	input wire rst,
	// program and data sides
	input wire [11:0] progAddr_r,
	input wire [7:0] progData,
	input wire [7:0] dataAddr_r,
	input wire [7:0] dataRdata,
	input wire [7:0] dataWdata_r,
	input wire dataWe_r,
	// pins and status
	input wire irqReq,
	input wire wdogSel,
	input wire [7:0] acc_r,
	input wire zero_r,
	input wire carry_r,
	input wire stopMode_r,
	input wire waitMode_r,
	input wire instrStart
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// opcode in cycle 0; instrStart already drops when an interrupt takes the slot
	wire go = instrStart;
	// end of an instruction after two, four or five cycles
	sequence done2;
		!instrStart ##1 instrStart;
	endsequence
	sequence done4;
		!instrStart [*3] ##1 instrStart;
	endsequence
	sequence done5;
		!instrStart [*4] ##1 instrStart;
	endsequence
	AST_REL_TWO: assert property (go && !progData[7] |=> done2)
		else $error("relative branch length wrong");
	AST_REL_FLAGS: assert property (go && !progData[7] |-> ##2 zero_r == $past(zero_r, 2) && carry_r == $past(carry_r, 2))
		else $error("relative branch changed flags");
	AST_ALU_FOUR: assert property (go && progData[7:5] == 3'h5 |=> done4)
		else $error("arithmetic length wrong");
	AST_BTB_FIVE: assert property (go && progData[7:4] == 4'h8 |=> done5)
		else $error("bit test branch length wrong");
	AST_CTL_TWO: assert property (go && progData inside {8'hD0, 8'hD1, 8'hD2} |=> done2)
		else $error("control op length wrong");
	AST_JMP_TARGET: assert property (go && progData[7:4] == 4'hE |=> ##3 instrStart
		&& progAddr_r == {$past(progData[3:0], 4), $past(progData, 3)})
		else $error("jump target wrong");
	AST_BIT_WRITE: assert property (go && progData[7:4] == 4'h9 |-> ##3 dataWe_r && dataAddr_r == $past(progData, 2)
		&& dataWdata_r[$past(progData[2:0], 3)] == $past(progData[3], 3))
		else $error("bit set or clear write wrong");
	AST_BIT_FLAGS: assert property (go && progData[7:4] == 4'h9 |-> ##4 zero_r == $past(zero_r, 4)
		&& carry_r == $past(carry_r, 4))
		else $error("bit set or clear changed flags");
	AST_CMP_KEEP: assert property (go && progData[7:2] == 6'h2A |-> ##4 acc_r == $past(acc_r, 4))
		else $error("compare wrote accumulator");
	AST_INC_CARRY: assert property (go && (progData[7:3] == 5'h16 || progData[7:4] == 4'hC)
		|-> ##4 carry_r == $past(carry_r, 4))
		else $error("increment or decrement changed carry");
	AST_STOP_MODE: assert property (go && progData == 8'hD3 |-> ##2 stopMode_r != waitMode_r
		&& waitMode_r == $past(wdogSel, 2))
		else $error("stop mode selection wrong");
endmodule

bind mcx_core_exec mcx_core_exec_checker i_chk (.sys_clk(sys_clk), .rst(rst), .progAddr_r(progAddr_r),
	.progData(progData), .dataAddr_r(dataAddr_r), .dataRdata(dataRdata), .dataWdata_r(dataWdata_r),
	.dataWe_r(dataWe_r), .irqReq(irqReq), .wdogSel(wdogSel), .acc_r(acc_r), .zero_r(zero_r), .carry_r(carry_r),
	.stopMode_r(stopMode_r), .waitMode_r(waitMode_r), .instrStart(instrStart));

/* File: test/mcx_mem_model.sv */
// program memory and data space seen by the core
`timescale 1ns/1ps
module mcx_mem_model (
	// clock
	input wire sys_clk,
	// program side
	input wire [11:0] progAddr,
	output wire [7:0] progData,
	// data side
	input wire [7:0] dataAddr,
	output wire [7:0] dataRdata,
	input wire [7:0] dataWdata,
	input wire dataWe
);
	logic [7:0] prog [0:4095];
	logic [7:0] dmem [0:255];
	// both reads answer in the same cycle
	assign progData = prog[progAddr];
	assign dataRdata = dmem[dataAddr];
	// write lands on the edge ending the strobe cycle
	always @(posedge sys_clk) begin
		if (dataWe)
			dmem[dataAddr] <= dataWdata;
	end
endmodule

/* File: test/mcx_core_exec_tb.sv */
// self-checking bench for the execution core
`timescale 1ns/1ps
module mcx_core_exec_tb;
	logic sys_clk = 0, rst = 1, irqReq = 0, wdogSel = 0;
	wire [11:0] progAddr_r;
	wire [7:0] progData, dataAddr_r, dataRdata, dataWdata_r, acc_r;
	wire dataWe_r, zero_r, carry_r, stopMode_r, waitMode_r, instrStart;
	int mismatches = 0, n_checks = 0;
	mcx_core_exec i_dut (.sys_clk(sys_clk), .rst(rst), .progAddr_r(progAddr_r), .progData(progData),
		.dataAddr_r(dataAddr_r), .dataRdata(dataRdata), .dataWdata_r(dataWdata_r), .dataWe_r(dataWe_r),
		.irqReq(irqReq), .wdogSel(wdogSel), .acc_r(acc_r), .zero_r(zero_r), .carry_r(carry_r),
		.stopMode_r(stopMode_r), .waitMode_r(waitMode_r), .instrStart(instrStart));
	mcx_mem_model i_mem (.sys_clk(sys_clk), .progAddr(progAddr_r), .progData(progData), .dataAddr(dataAddr_r),
		.dataRdata(dataRdata), .dataWdata(dataWdata_r), .dataWe(dataWe_r));
	// 100 MHz clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task chk(input string n, input logic [11:0] e, input logic [11:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task fl(input logic [7:0] a, input logic z, input logic c);
		chk("acc", {4'h0, a}, {4'h0, acc_r});
		chk("zero", {11'h0, z}, {11'h0, zero_r});
		chk("carry", {11'h0, c}, {11'h0, carry_r});
	endtask
	task put(input int a, input logic [7:0] q[$]);
		foreach (q[i]) i_mem.prog[a + i] = q[i];
	endtask
	// reset with unused program space filled by no-ops
	task hold(input logic wd);
		@(negedge sys_clk);
		rst = 1;
		wdogSel = wd;
		foreach (i_mem.prog[i]) i_mem.prog[i] = 8'hD0;
	endtask
	task go;
		repeat (3) @(negedge sys_clk);
		rst = 0;
	endtask
	// bounded wait for the next opcode cycle
	task step(input logic [11:0] ea, input int ec);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (instrStart !== 1'b1 && n < 40);
		// a run-out limit counts as a mismatch
		chk("start", 12'h001, {11'h0, instrStart});
		chk("pc", ea, progAddr_r);
		if (ec > 0)
			chk("cycles", ec[11:0], n[11:0]);
	endtask
	task t_alu;
		hold(0);
		put(0, '{8'hA3, 8'hF0, 8'hA3, 8'h20, 8'hAB, 8'h10, 8'hAF, 8'h11, 8'hA7, 8'h00, 8'hD5, 8'hD7, 8'h00, 8'hD6,
			8'hD8, 8'h00});
		go;
		step(12'h002, 4);
		fl(8'hF0, 0, 0);
		step(12'h004, 4);
		fl(8'h10, 0, 1);
		step(12'h006, 4);
		fl(8'h10, 1, 0);
		step(12'h008, 4);
		fl(8'hFF, 0, 1);
		step(12'h00A, 4);
		fl(8'h00, 1, 0);
		step(12'h00B, 4);
		fl(8'hFF, 0, 0);
		step(12'h00D, 4);
		fl(8'hFE, 0, 1);
		step(12'h00E, 4);
		fl(8'hFD, 0, 1);
		step(12'h010, 4);
		fl(8'h00, 1, 0);
	endtask
	task t_mem;
		hold(0);
		i_mem.dmem[8'h55] = 8'hFF;
		i_mem.dmem[8'h56] = 8'h05;
		i_mem.dmem[8'h57] = 8'h77;
		i_mem.dmem[8'h80] = 8'h60;
		i_mem.dmem[8'h83] = 8'hFF;
		i_mem.dmem[8'h60] = 8'h12;
		put(0, '{8'hA3, 8'hFF, 8'hA3, 8'h01, 8'hB2, 8'h55, 8'hB6, 8'h56, 8'hC3, 8'hBA, 8'h57, 8'h00, 8'hA0});
		go;
		step(12'h002, 4);
		step(12'h004, 4);
		step(12'h006, 4);
		chk("inc", 12'h000, {4'h0, i_mem.dmem[8'h55]});
		fl(8'h00, 1, 1);
		step(12'h008, 4);
		chk("dec", 12'h004, {4'h0, i_mem.dmem[8'h56]});
		fl(8'h00, 0, 1);
		step(12'h009, 4);
		chk("short", 12'h000, {4'h0, i_mem.dmem[8'h83]});
		step(12'h00C, 4);
		chk("clr", 12'h000, {4'h0, i_mem.dmem[8'h57]});
		fl(8'h00, 1, 1);
		step(12'h00D, 4);
		fl(8'h12, 0, 0);
	endtask
	task t_br;
		hold(0);
		put(0, '{8'hE1, 8'h23});
		put('h123, '{8'h0F});
		put('h133, '{8'h30});
		put('h124, '{8'h45, 8'h65, 8'hA3, 8'h00, 8'h42});
		put('h12B, '{8'h62, 8'h02, 8'h22});
		go;
		step(12'h123, 4);
		step(12'h133, 2);
		step(12'h124, 2);
		step(12'h125, 2);
		step(12'h126, 2);
		step(12'h128, 4);
		step(12'h12B, 2);
		step(12'h12C, 2);
		step(12'h12D, 2);
		step(12'h130, 2);
		fl(8'h00, 1, 0);
	endtask
	task t_bit;
		hold(0);
		i_mem.dmem[8'h70] = 8'h00;
		i_mem.dmem[8'h71] = 8'hFF;
		put(0, '{8'h9F, 8'h70, 8'h90, 8'h71, 8'h8F, 8'h70, 8'h7F, 8'h87, 8'h70, 8'h10});
		put('h85, '{8'h80, 8'h71, 8'h80});
		go;
		step(12'h002, 4);
		chk("set", 12'h080, {4'h0, i_mem.dmem[8'h70]});
		step(12'h004, 4);
		chk("clear", 12'h0FE, {4'h0, i_mem.dmem[8'h71]});
		fl(8'h00, 0, 0);
		step(12'h085, 5);
		fl(8'h00, 0, 1);
		step(12'h007, 5);
		fl(8'h00, 0, 0);
		step(12'h00A, 5);
		fl(8'h00, 0, 1);
	endtask
	task t_ctl;
		hold(0);
		put(0, '{8'hF2, 8'h00, 8'hA3, 8'hFF, 8'hA3, 8'h01, 8'hD3, 8'hD4});
		put('h200, '{8'hD0, 8'hD1});
		put('hFF0, '{8'hA7, 8'h01, 8'hD2});
		go;
		step(12'h200, 4);
		step(12'h201, 2);
		step(12'h002, 2);
		step(12'h004, 4);
		step(12'h006, 4);
		repeat (4) @(negedge sys_clk);
		chk("stop", 12'h001, {11'h0, stopMode_r});
		chk("held", 12'h007, progAddr_r);
		irqReq = 1;
		step(12'hFF0, 0);
		irqReq = 0;
		step(12'hFF2, 4);
		fl(8'h00, 1, 0);
		step(12'h007, 2);
		fl(8'h00, 1, 1);
		repeat (4) @(negedge sys_clk);
		chk("wait", 12'h001, {11'h0, waitMode_r});
	endtask
	task t_wd;
		hold(1);
		// no-op first: the select needs two edges through its synchroniser after reset
		put(0, '{8'hD0, 8'hD3});
		go;
		repeat (4) @(negedge sys_clk);
		chk("wdwait", 12'h001, {11'h0, waitMode_r});
		chk("wdstop", 12'h000, {11'h0, stopMode_r});
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// scenarios in order
	initial begin
		t_alu;
		t_mem;
		t_br;
		t_bit;
		t_ctl;
		t_wd;
		tally_and_finish;
	end
	// hang guard, far beyond the fewer than two hundred cycles needed
	initial begin
		#100000;
		mismatches++;
		tally_and_finish;
	end
endmodule
